// >>> pkg/pmj_pkg.sv
// Purpose: Constants for the program memory map and jump target logic.
// Assumes: 16-bit address space, 8-bit memory bytes.
// Notes: Region bounds and table bases are used by the decoder and sequencer.
`default_nettype none
package pmj_pkg;
	localparam logic [15:0] ROM_BASE = 16'h8000;
	localparam logic [15:0] RAM_BASE = 16'h0040;
	localparam logic [15:0] RAM_LAST = 16'h043F;
	localparam logic [15:0] BANK_BASE = 16'h0040;
	localparam logic [15:0] BANK_LAST = 16'h00BF;
	localparam logic [15:0] SFR_LAST = 16'h003F;
	localparam logic [15:0] DBR_BASE = 16'h0F80;
	localparam logic [15:0] DBR_LAST = 16'h0FFF;
	localparam logic [15:0] IRQ_TABLE = 16'hFFE0;
	localparam logic [15:0] RESET_HI = 16'hFFFF;
	localparam logic [15:0] RESET_LO = 16'hFFFE;
	localparam logic [15:0] VCALL_TABLE = 16'hFFC0;
	localparam logic [15:0] PAGE_BASE = 16'hFF00;
	localparam logic [15:0] PREFETCH = 16'h0002;
	// Region codes shown on o_region.
	localparam logic [1:0] REG_SFR = 2'h0;
	localparam logic [1:0] REG_RAM = 2'h1;
	localparam logic [1:0] REG_DBR = 2'h2;
	localparam logic [1:0] REG_ROM = 2'h3;
	// Operation codes on i_op.
	localparam logic [2:0] OP_NONE = 3'h0;
	localparam logic [2:0] OP_SHORT_REL = 3'h1;
	localparam logic [2:0] OP_BYTE_REL = 3'h2;
	localparam logic [2:0] OP_ABS = 3'h3;
	localparam logic [2:0] OP_VCALL = 3'h4;
	localparam logic [2:0] OP_PCALL = 3'h5;
	localparam logic [2:0] OP_PC_A_JUMP = 3'h6;
	localparam logic [2:0] OP_IRQ = 3'h7;
	typedef enum {ST_RST_LO, ST_RST_HI, ST_RUN, ST_VEC_LO, ST_VEC_HI}
		pmj_state_t;
endpackage
`default_nettype wire

// >>> src/pmj_core.sv
// Purpose: Program counter sequencing, jump targets and address decode.
// Assumes: Memory answers a read with data in the next cycle.
// Notes: One address port is shared by fetch, table reads and data reads.
// Overview of operation
// - Sixteen-bit addresses cover one 64K space.
// - Four regions: ROM, RAM, two I/O spaces.
// - Sixteen register banks overlay lowest 128 RAM bytes.
// - ROM is 32K at 8000 to FFFF.
// - Reset and fifteen interrupt vectors at FFE0.
// - Vector call reads sixteen entries ending FFDF.
// - Page call targets lie in FF00 to FFFF.
// - Fetch next instruction at program counter minus two.
// - Jump targets are plain sixteen-bit sums.
// - Relative base is instruction address plus two.
// - Short jump adds five-bit displacement when true.
// - Byte jump sign-extends eight-bit displacement.
// - Absolute jump loads full operand unconditionally.
// - Data reads reach ROM in program region.
// - PC plus accumulator for reads and jumps.
// - Reset loads PC from FFFF and FFFE.
// - PC runs two beyond executing instruction.
`default_nettype none
module pmj_core (
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	// Instruction step from the decoder.
	input wire logic i_step,
	input wire logic [2:0] i_op,
	input wire logic i_cond,
	input wire logic [1:0] i_len,
	input wire logic [15:0] i_operand,
	input wire logic [7:0] i_acc,
	input wire logic [3:0] i_irq_num,
	// Data read request.
	input wire logic i_dread,
	input wire logic i_dread_pc_a,
	input wire logic [15:0] i_daddr,
	// Memory read data.
	input wire logic [7:0] i_mem_rdata,
	// Memory address and decode.
	output logic [15:0] o_addr,
	output logic [1:0] o_region,
	output logic o_rom_sel,
	output logic o_bank_hit,
	output logic [3:0] o_bank,
	output logic o_data_cycle,
	// Core status.
	output logic [15:0] o_pc,
	output logic o_busy,
	output logic o_taken
);
	typedef struct packed {
		pmj_pkg::pmj_state_t st;
		logic [15:0] pc;
		logic [15:0] addr;
		logic [7:0] lo;
		logic data_cycle;
		logic taken;
	} pmj_regs_t;

	pmj_regs_t r;
	pmj_regs_t next_r;
	logic [15:0] base;
	logic [15:0] disp5;
	logic [15:0] disp8;
	logic [15:0] bank_off;

	// Relative base is the instruction address plus two, i.e. the PC.
	always_comb begin
		base = r.pc;
		disp5 = {11'h000, i_operand[4:0]};
		disp8 = {{8{i_operand[7]}}, i_operand[7:0]};
	end

	// Sequencer: vector loads, jumps, fetch and data reads.
	always_comb begin
		next_r = r;
		next_r.taken = 1'b0;
		next_r.data_cycle = 1'b0;
		case (r.st)
			pmj_pkg::ST_RST_LO: begin
				next_r.addr = pmj_pkg::RESET_LO;
				next_r.st = pmj_pkg::ST_RST_HI;
			end
			pmj_pkg::ST_RST_HI: begin
				next_r.lo = i_mem_rdata;
				next_r.addr = pmj_pkg::RESET_HI;
				next_r.st = pmj_pkg::ST_VEC_HI;
			end
			pmj_pkg::ST_VEC_LO: begin
				next_r.lo = i_mem_rdata;
				next_r.addr = r.addr + 16'h0001;
				next_r.st = pmj_pkg::ST_VEC_HI;
			end
			pmj_pkg::ST_VEC_HI: begin
				// High byte sits at the higher table address.
				next_r.pc = {i_mem_rdata, r.lo} + pmj_pkg::PREFETCH;
				next_r.addr = {i_mem_rdata, r.lo};
				next_r.taken = 1'b1;
				next_r.st = pmj_pkg::ST_RUN;
			end
			pmj_pkg::ST_RUN: begin
				if (i_dread) begin
					// Any address may be read; ROM is included.
					next_r.addr = i_dread_pc_a ? r.pc + {8'h00, i_acc}
						: i_daddr;
					next_r.data_cycle = 1'b1;
				end else if (i_step) begin
					next_r.pc = r.pc + {14'h0000, i_len};
					case (i_op)
						pmj_pkg::OP_SHORT_REL: begin
							if (i_cond) begin
								next_r.pc = base + disp5 + pmj_pkg::PREFETCH;
								next_r.taken = 1'b1;
							end
						end
						pmj_pkg::OP_BYTE_REL: begin
							if (i_cond) begin
								next_r.pc = base + disp8 + pmj_pkg::PREFETCH;
								next_r.taken = 1'b1;
							end
						end
						pmj_pkg::OP_ABS: begin
							next_r.pc = i_operand + pmj_pkg::PREFETCH;
							next_r.taken = 1'b1;
						end
						pmj_pkg::OP_PC_A_JUMP: begin
							next_r.pc = base + {8'h00, i_acc}
								+ pmj_pkg::PREFETCH;
							next_r.taken = 1'b1;
						end
						pmj_pkg::OP_PCALL: begin
							next_r.pc = pmj_pkg::PAGE_BASE + {8'h00, i_operand[7:0]}
								+ pmj_pkg::PREFETCH;
							next_r.taken = 1'b1;
						end
						pmj_pkg::OP_VCALL: begin
							next_r.addr = pmj_pkg::VCALL_TABLE
								+ {11'h000, i_operand[3:0], 1'b0};
							next_r.st = pmj_pkg::ST_VEC_LO;
						end
						pmj_pkg::OP_IRQ: begin
							next_r.addr = pmj_pkg::IRQ_TABLE
								+ {11'h000, i_irq_num, 1'b0};
							next_r.st = pmj_pkg::ST_VEC_LO;
						end
						default: begin
						end
					endcase
					if (next_r.st == pmj_pkg::ST_RUN) begin
						next_r.addr = next_r.pc - pmj_pkg::PREFETCH;
					end
				end else begin
					next_r.addr = r.pc - pmj_pkg::PREFETCH;
				end
			end
			default: begin
				next_r.st = pmj_pkg::ST_RST_LO;
			end
		endcase
	end

	// State register.
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			r <= '{st: pmj_pkg::ST_RST_LO, pc: 16'h0000, addr: 16'h0000,
				lo: 8'h00, data_cycle: 1'b0, taken: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	// Region decode of the current address.
	always_comb begin
		o_bank_hit = (r.addr >= pmj_pkg::BANK_BASE)
			&& (r.addr <= pmj_pkg::BANK_LAST);
		// Bank 0 starts at the base of the bank area, eight bytes a bank.
		bank_off = r.addr - pmj_pkg::BANK_BASE;
		o_bank = bank_off[6:3];
		o_rom_sel = r.addr[15];
		if (r.addr >= pmj_pkg::ROM_BASE) begin
			o_region = pmj_pkg::REG_ROM;
		end else if (r.addr >= pmj_pkg::DBR_BASE
			&& r.addr <= pmj_pkg::DBR_LAST) begin
			o_region = pmj_pkg::REG_DBR;
		end else if (r.addr <= pmj_pkg::SFR_LAST) begin
			o_region = pmj_pkg::REG_SFR;
		end else begin
			o_region = pmj_pkg::REG_RAM;
		end
	end

	// Registered outputs; o_busy is decoded from the state register.
	assign o_addr = r.addr;
	assign o_pc = r.pc;
	assign o_data_cycle = r.data_cycle;
	assign o_taken = r.taken;
	assign o_busy = (r.st != pmj_pkg::ST_RUN);
endmodule
`default_nettype wire

// >>> testbench/pmj_mem_model.sv
// Purpose: Memory model that answers the registered address at once.
// Assumes: Odd bytes hold C0, even bytes hold their low address byte.
// Notes: Every table entry thus points into the program region.
`default_nettype none
module pmj_mem_model (
	// Clock and address.
	input wire logic i_sys_clk,
	input wire logic [15:0] i_addr,
	// Read data.
	output logic [7:0] o_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// The high byte of an entry sits at the odd address.
	// The core registers the address, so data is ready by the next edge.
	always_comb begin
		o_rdata = i_addr[0] ? 8'hC0 : i_addr[7:0];
	end
endmodule
`default_nettype wire

// >>> testbench/pmj_checker.sv
// Purpose: Assertions on jump targets and address decode.
// Assumes: A step is taken only while not busy.
// Notes: Bound to the core.
`default_nettype none
module pmj_checker (
	// Core ports.
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_step,
	input wire logic [2:0] i_op,
	input wire logic i_cond,
	input wire logic [1:0] i_len,
	input wire logic [15:0] i_operand,
	input wire logic i_dread,
	input wire logic i_dread_pc_a,
	input wire logic [15:0] i_daddr,
	input wire logic [15:0] o_addr,
	input wire logic [1:0] o_region,
	input wire logic o_rom_sel,
	input wire logic o_bank_hit,
	input wire logic [3:0] o_bank,
	input wire logic o_data_cycle,
	input wire logic [15:0] o_pc,
	input wire logic o_busy,
	input wire logic o_taken
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	logic go;
	logic [15:0] d8, d5, n2, bk;
	// Accepted step, widened displacements and bank offset.
	assign go = i_step && !o_busy && !i_dread;
	assign d8 = {{8{i_operand[7]}}, i_operand[7:0]};
	assign d5 = {11'h0, i_operand[4:0]};
	assign n2 = {11'h0, i_operand[3:0], 1'b0};
	assign bk = o_addr - pmj_pkg::BANK_BASE;
	property p_abs;
		go && i_op == 3'h3 |=> o_taken && o_addr == $past(i_operand);
	endproperty
	a_abs: assert property (p_abs) else $error("abs");
	property p_rel8;
		go && i_op == 3'h2 && i_cond |=> o_addr == $past(o_pc) + $past(d8);
	endproperty
	a_rel8: assert property (p_rel8) else $error("rel8");
	property p_rel5;
		go && i_op == 3'h1 && i_cond |=> o_addr == $past(o_pc) + $past(d5);
	endproperty
	a_rel5: assert property (p_rel5) else $error("rel5");
	property p_pc2;
		o_taken |-> o_pc == o_addr + 16'h2;
	endproperty
	a_pc2: assert property (p_pc2) else $error("pc2");
	property p_vec;
		go && i_op == 3'h4 |=> o_busy && o_addr == 16'hFFC0 + $past(n2)
			##1 o_addr == 16'hFFC1 + $past(n2, 2) ##1 o_taken;
	endproperty
	a_vec: assert property (p_vec) else $error("vec");
	property p_rd;
		i_dread && !i_dread_pc_a && !o_busy
			|=> o_data_cycle && o_addr == $past(i_daddr);
	endproperty
	a_rd: assert property (p_rd) else $error("rd");
	property p_rom;
		o_rom_sel == o_addr[15] && (o_region == 2'h3) == o_addr[15];
	endproperty
	a_rom: assert property (p_rom) else $error("rom");
	property p_bank;
		o_bank_hit |-> bk < 16'h80 && o_bank == bk[6:3];
	endproperty
	a_bank: assert property (p_bank) else $error("bank");
	c_abs: cover property (go && i_op == 3'h3);
	c_vec: cover property (go && i_op == 3'h4);
	c_rd: cover property (i_dread);
endmodule
bind pmj_core pmj_checker u_chk (.*);
`default_nettype wire

// >>> testbench/testbench.sv
// Purpose: Directed tests of program counter and address map.
// Assumes: Memory model content fixes every expected entry.
// Notes: Inputs change 1 ns after the rising edge.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk = 0, i_nrst = 0, i_step = 0, i_cond = 0, i_dread = 0;
	logic i_dread_pc_a = 0;
	logic [2:0] i_op = '0;
	logic [1:0] i_len = 2'h2;
	logic [15:0] i_operand = '0, i_daddr = '0, o_addr, o_pc;
	logic [7:0] i_acc = '0, rdata;
	logic [3:0] i_irq_num = '0, o_bank;
	logic [1:0] o_region;
	logic o_rom_sel, o_bank_hit, o_data_cycle, o_busy, o_taken;
	int error_cnt = 0, check_count = 0, cyc = 0;
	pmj_core u_dut (.i_sys_clk, .i_nrst, .i_step, .i_op, .i_cond, .i_len,
		.i_operand, .i_acc, .i_irq_num, .i_dread, .i_dread_pc_a,
		.i_daddr, .i_mem_rdata(rdata), .o_addr, .o_region, .o_rom_sel,
		.o_bank_hit, .o_bank, .o_data_cycle, .o_pc, .o_busy, .o_taken);
	pmj_mem_model u_mem (.i_sys_clk, .i_addr(o_addr), .o_rdata(rdata));
	// Clock and hang guard.
	initial forever #2.5 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) if (++cyc == 400) begin
		error_cnt++;
		print_verdict();
	end
	task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic wt(int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	task automatic step(logic [2:0] op, logic c, logic [15:0] v);
		wt(1);
		i_op = op;
		i_cond = c;
		i_operand = v;
		i_step = 1;
		wt(1);
		i_step = 0;
	endtask
	task automatic t_reset;
		wt(6);
		i_nrst = 1;
		wt(3);
		chk("pc", 16'hC100, o_pc);
		chk("addr", 16'hC0FE, o_addr);
		$display("t_reset done");
	endtask
	task automatic t_jumps;
		step(3'h3, 0, 16'hC235);
		chk("pc", 16'hC237, o_pc);
		chk("taken", 16'h0001, {15'h0, o_taken});
		step(3'h2, 1, 16'h0080);
		chk("addr", 16'hC1B7, o_addr);
		step(3'h1, 1, 16'h0008);
		chk("addr", 16'hC1C1, o_addr);
		i_len = 2'h1;
		step(3'h1, 0, 16'h0008);
		chk("pc", 16'hC1C4, o_pc);
		i_acc = 8'h10;
		step(3'h6, 0, 16'h0000);
		chk("pca", 16'hC1D4, o_addr);
		$display("t_jumps done");
	endtask
	task automatic t_calls;
		step(3'h4, 0, 16'h000F);
		wt(2);
		chk("pc", 16'hC0E0, o_pc);
		step(3'h5, 0, 16'h0040);
		chk("pc", 16'hFF42, o_pc);
		i_irq_num = 4'h3;
		step(3'h7, 0, 16'h0000);
		wt(2);
		chk("pc", 16'hC0E8, o_pc);
		$display("t_calls done");
	endtask
	task automatic t_reads;
		i_dread = 1;
		i_daddr = 16'h8123;
		wt(1);
		chk("rom", 16'h3, {14'h0, o_region});
		chk("romsel", 16'h1, {15'h0, o_rom_sel});
		chk("dcyc", 16'h1, {15'h0, o_data_cycle});
		i_daddr = 16'h0048;
		wt(1);
		chk("bank", 16'h1, {12'h0, o_bank});
		chk("ram", 16'h1, {14'h0, o_region});
		chk("hit", 16'h1, {15'h0, o_bank_hit});
		i_dread_pc_a = 1;
		wt(1);
		chk("rdpca", 16'hC0F8, o_addr);
		i_dread = 0;
		i_dread_pc_a = 0;
		$display("t_reads done");
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Main sequence.
	initial begin
		t_reset();
		t_jumps();
		t_calls();
		t_reads();
		print_verdict();
	end
endmodule
`default_nettype wire
